// *** touch_sampling_sequencer_consts.vh ***
// Constants for the touch sampling sequencer: offsets, fields, resets, timing
`ifndef TOUCH_SAMPLING_SEQUENCER_CONSTS_VH
`define TOUCH_SAMPLING_SEQUENCER_CONSTS_VH

// ==========================================================================
// Register offsets
`define ADDR_INPUT_ENABLE        8'h21
`define ADDR_AVG_SAMPLING_CONFIG 8'h24
`define ADDR_RECAL_TRIGGER       8'h26

// ==========================================================================
// Reset values
`define RST_INPUT_ENABLE         8'hFF
`define RST_AVG_SAMPLING_CONFIG  8'h39
`define RST_RECAL_TRIGGER        8'h00

// ==========================================================================
// Field positions in the averaging and sampling config register
`define AVG_MSB                  6
`define AVG_LSB                  4
`define SAMP_MSB                 3
`define SAMP_LSB                 2
`define CYC_MSB                  1
`define CYC_LSB                  0
`define CONFIG_USED_MASK         8'h7F

// ==========================================================================
// Timing, in nanoseconds
`define CLK_PERIOD_NS            10
`define SAMPLE_BASE_NS           320000
`define CYCLE_BASE_NS            35000000
`define RECAL_TIME_NS            600000000

`endif

// *** touch_sampling_sequencer.v ***
// Touch sampling sequencer: per-cycle channel averaging and input recalibration
//
// Behaviour
// - Averaging code 000..111 selects 1..128 samples per channel; default 8.
// - All samples of a channel run back to back, then averaged, then reported.
// - Sample duration code selects 320us, 640us, 1.28ms or 2.56ms.
// - Cycle period code selects 35ms, 70ms, 105ms or 140ms.
// - Channels are sampled at cycle start; remaining time is spent in low power.
// - If sampling outlasts the period, the cycle stretches until sampling ends.
// - Config register at 24h resets to 39h and acts only in Active state.
// - Software sets a trigger bit at 26h; hardware clears it on successful recalibration.
// - A recalibrating input has press detection masked; its measurements are still reported.
// - A press during recalibration invalidates that attempt.
// - A finished recalibration updates that input's ten-bit calibration value.
// - Trigger bit n controls input n+1, bit 7 input 8 down to bit 0 input 1.
// - Only enabled inputs are sampled; cycle period ignores the count of inputs.
`include "touch_sampling_sequencer_consts.vh"

module touch_sampling_sequencer #(
  parameter [31:0] SAMPLE_UNIT_CYCLES = `SAMPLE_BASE_NS / `CLK_PERIOD_NS,
  parameter [31:0] CYCLE_UNIT_CYCLES  = `CYCLE_BASE_NS / `CLK_PERIOD_NS,
  parameter [31:0] RECAL_CYCLES       = `RECAL_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire        core_clk_i,
  input  wire        rstn_i,
  input  wire        active_state_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire [15:0] sample_data_i,
  input  wire [7:0]  press_i,
  input  wire [9:0]  cal_code_i,
  output wire        sampling_o,
  output wire        low_power_o,
  output reg  [2:0]  sample_ch_o,
  output reg         meas_valid_o,
  output reg  [2:0]  meas_ch_o,
  output reg  [15:0] meas_result_o,
  output reg  [7:0]  press_detect_o,
  output reg  [7:0]  recal_busy_o,
  output reg         cal_update_o,
  output reg  [2:0]  cal_ch_o,
  output reg  [9:0]  input_calibration_value_o
);

  // ========================================================================
  // Helpers
  localparam ST_IDLE   = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_REST   = 3'b100;

  // Lowest set bit at or above start; MSB of result flags a hit
  function [3:0] find_next;
    input [7:0] mask;
    input [3:0] start;
    integer k;
    reg hit;
    begin
      find_next = 4'h0;
      hit = 1'b0;
      for (k = 0; k < 8; k = k + 1)
        if (!hit && k >= start && mask[k])
        begin
          find_next = {1'b1, k[2:0]};
          hit = 1'b1;
        end
    end
  endfunction

  // Write strobe aimed at one register offset
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] offset;
    begin
      wr_hit = wr && (addr == offset);
    end
  endfunction

  // ========================================================================
  // Registers
  reg  [7:0]  input_enable;
  reg  [7:0]  avg_sampling_config;
  reg  [7:0]  recalibration_trigger;
  reg  [7:0]  recal_clear;

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      input_enable          <= `RST_INPUT_ENABLE;
      avg_sampling_config   <= `RST_AVG_SAMPLING_CONFIG;
      recalibration_trigger <= `RST_RECAL_TRIGGER;
      reg_rdata_o           <= 8'h00;
    end
    else
    begin
      if (wr_hit(reg_wr_i, reg_addr_i, `ADDR_INPUT_ENABLE))
        input_enable <= reg_wdata_i;
      if (wr_hit(reg_wr_i, reg_addr_i, `ADDR_AVG_SAMPLING_CONFIG))
        avg_sampling_config <= reg_wdata_i & `CONFIG_USED_MASK;
      // A write in the same cycle as a hardware clear wins, so a fresh set is kept
      if (wr_hit(reg_wr_i, reg_addr_i, `ADDR_RECAL_TRIGGER))
        recalibration_trigger <= reg_wdata_i;
      else
        recalibration_trigger <= recalibration_trigger & ~recal_clear;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `ADDR_INPUT_ENABLE:        reg_rdata_o <= input_enable;
          `ADDR_AVG_SAMPLING_CONFIG: reg_rdata_o <= avg_sampling_config;
          `ADDR_RECAL_TRIGGER:       reg_rdata_o <= recalibration_trigger;
          default:                   reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ========================================================================
  // Sampling sequencer
  reg  [2:0]  state;
  reg  [7:0]  en_snap;
  reg  [2:0]  avg_snap;
  reg  [1:0]  samp_snap;
  reg  [1:0]  cyc_snap;
  reg  [31:0] samp_tmr;
  reg  [31:0] cyc_cnt;
  reg  [6:0]  samp_cnt;
  reg  [22:0] acc;

  wire [3:0]  first_hit = find_next(input_enable, 4'h0);
  wire [3:0]  next_hit  = find_next(en_snap, {1'b0, sample_ch_o} + 4'h1);
  wire [31:0] samp_len  = SAMPLE_UNIT_CYCLES << samp_snap;
  wire [31:0] cyc_len   = CYCLE_UNIT_CYCLES * ({30'h0, cyc_snap} + 32'h1);
  wire [6:0]  cnt_last  = 7'h7F >> (3'h7 - avg_snap);
  wire [22:0] acc_sum   = acc + {7'h00, sample_data_i};
  wire [22:0] avg_val   = acc_sum >> avg_snap;

  assign sampling_o  = state[1];
  assign low_power_o = state[2];

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      state         <= ST_IDLE;
      en_snap       <= 8'h00;
      avg_snap      <= 3'h0;
      samp_snap     <= 2'h0;
      cyc_snap      <= 2'h0;
      samp_tmr      <= 32'h0;
      cyc_cnt       <= 32'h0;
      samp_cnt      <= 7'h00;
      acc           <= 23'h0;
      sample_ch_o   <= 3'h0;
      meas_valid_o  <= 1'b0;
      meas_ch_o     <= 3'h0;
      meas_result_o <= 16'h0000;
    end
    else
    begin
      meas_valid_o <= 1'b0;
      cyc_cnt      <= cyc_cnt + 32'h1;
      if (!active_state_i)
      begin
        // Settings govern sampling only in Active state
        state    <= ST_IDLE;
        samp_tmr <= 32'h0;
        samp_cnt <= 7'h00;
        acc      <= 23'h0;
      end
      else
      begin
        case (state)
          ST_IDLE, ST_REST:
          begin
            // Period is checked only here, so an overlong sampling pass stretches it
            if (state == ST_IDLE || cyc_cnt >= cyc_len - 32'h1)
            begin
              // Config taken at cycle start keeps one cycle self-consistent
              en_snap     <= input_enable;
              avg_snap    <= avg_sampling_config[`AVG_MSB:`AVG_LSB];
              samp_snap   <= avg_sampling_config[`SAMP_MSB:`SAMP_LSB];
              cyc_snap    <= avg_sampling_config[`CYC_MSB:`CYC_LSB];
              cyc_cnt     <= 32'h0;
              samp_tmr    <= 32'h0;
              samp_cnt    <= 7'h00;
              acc         <= 23'h0;
              sample_ch_o <= first_hit[2:0];
              state       <= first_hit[3] ? ST_SAMPLE : ST_REST;
            end
          end
          ST_SAMPLE:
          begin
            if (samp_tmr >= samp_len - 32'h1)
            begin
              samp_tmr <= 32'h0;
              if (samp_cnt == cnt_last)
              begin
                meas_result_o <= avg_val[15:0];
                meas_ch_o     <= sample_ch_o;
                meas_valid_o  <= 1'b1;
                samp_cnt      <= 7'h00;
                acc           <= 23'h0;
                sample_ch_o   <= next_hit[2:0];
                if (!next_hit[3])
                  state <= ST_REST;
              end
              else
              begin
                // Same channel again until its count is done
                samp_cnt <= samp_cnt + 7'h01;
                acc      <= acc_sum;
              end
            end
            else
              samp_tmr <= samp_tmr + 32'h1;
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // Recalibration engine, one input at a time, lowest bit first
  reg         rc_busy;
  reg  [2:0]  rc_ch;
  reg  [31:0] rc_tmr;
  // A pressed input is passed over until released, so its mask never flickers on and off
  wire [3:0]  rc_pick = find_next(recalibration_trigger & ~press_i, 4'h0);
  wire [7:0]  rc_mask = rc_busy ? (8'h01 << rc_ch) : 8'h00;

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      rc_busy                   <= 1'b0;
      rc_ch                     <= 3'h0;
      rc_tmr                    <= 32'h0;
      recal_clear               <= 8'h00;
      recal_busy_o              <= 8'h00;
      press_detect_o            <= 8'h00;
      cal_update_o              <= 1'b0;
      cal_ch_o                  <= 3'h0;
      input_calibration_value_o <= 10'h000;
    end
    else
    begin
      recal_clear    <= 8'h00;
      cal_update_o   <= 1'b0;
      recal_busy_o   <= rc_mask;
      press_detect_o <= press_i & ~rc_mask;
      if (!rc_busy)
      begin
        // Wait out the clear of the last finished bit before picking again
        if (rc_pick[3] && recal_clear == 8'h00)
        begin
          rc_busy <= 1'b1;
          rc_ch   <= rc_pick[2:0];
          rc_tmr  <= 32'h0;
        end
      end
      else if (!recalibration_trigger[rc_ch] || press_i[rc_ch])
        // Bit stays set after a press, so the input retries
        rc_busy <= 1'b0;
      else if (rc_tmr >= RECAL_CYCLES - 32'h1)
      begin
        rc_busy                   <= 1'b0;
        recal_clear               <= 8'h01 << rc_ch;
        cal_update_o              <= 1'b1;
        cal_ch_o                  <= rc_ch;
        input_calibration_value_o <= cal_code_i;
      end
      else
        rc_tmr <= rc_tmr + 32'h1;
    end
  end

endmodule // touch_sampling_sequencer

// *** touch_sampling_sequencer_sva.sv ***
// Port assertions for the touch sampling sequencer
module touch_sampling_sequencer_sva (
  input logic        core_clk_i,
  input logic        rstn_i,
  input logic        active_state_i,
  input logic [7:0]  reg_addr_i,
  input logic        reg_rd_i,
  input logic [7:0]  reg_rdata_o,
  input logic [7:0]  press_i,
  input logic        sampling_o,
  input logic        low_power_o,
  input logic        meas_valid_o,
  input logic [15:0] meas_result_o,
  input logic [7:0]  press_detect_o,
  input logic [7:0]  recal_busy_o,
  input logic        cal_update_o,
  input logic [2:0]  cal_ch_o
);
  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_sample_rest_excl: assert property (!(sampling_o && low_power_o))
    else $error("sampling and rest overlap");
  a_inactive_idle: assert property (!active_state_i |=> !sampling_o && !low_power_o)
    else $error("running outside active");
  a_meas_pulse: assert property (meas_valid_o |=> !meas_valid_o)
    else $error("result strobe too long");
  a_result_hold: assert property (!meas_valid_o |-> $stable(meas_result_o))
    else $error("result moved without strobe");
  a_cfg_top_zero: assert property (reg_rd_i && reg_addr_i == 8'h24 |=> !reg_rdata_o[7])
    else $error("config bit 7 reads one");
  a_unmapped_zero: assert property (
    reg_rd_i && !(reg_addr_i inside {8'h21, 8'h24, 8'h26}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_busy_onehot: assert property ($onehot0(recal_busy_o))
    else $error("several inputs recalibrating");
  a_cal_channel: assert property (cal_update_o |-> $past(recal_busy_o) == (8'h01 << cal_ch_o))
    else $error("update for wrong input");
  a_cal_pulse: assert property (cal_update_o |=> !cal_update_o)
    else $error("update strobe too long");
  // Mask timing against the busy flag is checked by a_busy_masks_press below; here only the quiet case
  a_press_pass: assert property (
    recal_busy_o == 8'h00 && $past(recal_busy_o) == 8'h00 |-> press_detect_o == $past(press_i))
    else $error("press lost while not recalibrating");
  a_busy_masks_press: assert property ((press_detect_o & recal_busy_o) == 8'h00)
    else $error("press seen while recalibrating");
  a_no_update_press: assert property (
    cal_update_o |-> ($past(press_i) & $past(recal_busy_o)) == 8'h00)
    else $error("update despite press");
  c_result: cover property (meas_valid_o);
  c_cal: cover property (cal_update_o);
  c_rest: cover property ($rose(low_power_o));
endmodule // touch_sampling_sequencer_sva

bind touch_sampling_sequencer touch_sampling_sequencer_sva u_touch_sampling_sequencer_sva (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .active_state_i(active_state_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .press_i(press_i),
  .sampling_o(sampling_o), .low_power_o(low_power_o), .meas_valid_o(meas_valid_o),
  .meas_result_o(meas_result_o), .press_detect_o(press_detect_o),
  .recal_busy_o(recal_busy_o), .cal_update_o(cal_update_o), .cal_ch_o(cal_ch_o));

// *** touch_sampling_sequencer_bench.sv ***
// Self-checking bench for the touch sampling sequencer
module touch_sampling_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'h0;
  logic        rstn_i = 1'h0;
  logic        active_state_i = 1'h0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'h0;
  logic        reg_rd_i = 1'h0;
  logic [15:0] sample_data_i = 16'hFFFF;
  logic [7:0]  press_i = 8'h00;
  logic [9:0]  cal_code_i = 10'h2A5;
  wire  [7:0]  reg_rdata_o, press_detect_o, recal_busy_o;
  wire  [15:0] meas_result_o;
  wire  [9:0]  input_calibration_value_o;
  wire  [2:0]  sample_ch_o, meas_ch_o, cal_ch_o;
  wire         sampling_o, low_power_o, meas_valid_o, cal_update_o;
  int          miscompares = 0;
  int          tests_run = 0;
  int          n1, n2;
  // Rows: address, write data, read-back value
  logic [23:0] rows [4] = '{24'h24FF7F, 24'h33AA00, 24'h210606, 24'h242020};

  // Short unit counts keep every run to a few thousand cycles
  touch_sampling_sequencer #(.SAMPLE_UNIT_CYCLES(4), .CYCLE_UNIT_CYCLES(200),
    .RECAL_CYCLES(50)) u_touch_sampling_sequencer (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .active_state_i(active_state_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sample_data_i(sample_data_i),
    .press_i(press_i), .cal_code_i(cal_code_i), .sampling_o(sampling_o),
    .low_power_o(low_power_o), .sample_ch_o(sample_ch_o), .meas_valid_o(meas_valid_o),
    .meas_ch_o(meas_ch_o), .meas_result_o(meas_result_o), .press_detect_o(press_detect_o),
    .recal_busy_o(recal_busy_o), .cal_update_o(cal_update_o), .cal_ch_o(cal_ch_o),
    .input_calibration_value_o(input_calibration_value_o));

  // ==========================================================================
  // Helpers
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    @(negedge core_clk_i);
    reg_wr_i = 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    @(negedge core_clk_i);
    reg_rd_i = 1'h0;
    @(negedge core_clk_i);
    check(reg_rdata_o, exp);
  endtask

  // Steps at least one cycle so a pulse already seen is not counted twice
  task automatic wait_on(input int sel, output int k);
    k = 0;
    do
    begin
      @(negedge core_clk_i);
      k++;
    end
    while (k < 3000 && !(sel == 0 ? meas_valid_o === 1'h1 : sel == 1 ? cal_update_o === 1'h1 :
      sel == 2 ? low_power_o === 1'h1 : sel == 3 ? sampling_o === 1'h1 : |recal_busy_o));
    if (k >= 3000)
    begin
      miscompares++;
      $display("ERROR %0t: wait limit reached", $time);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(negedge core_clk_i);
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (12) @(negedge core_clk_i);
    rstn_i = 1'h1;
    rdc(8'h21, 8'hFF);
    rdc(8'h24, 8'h39);
    rdc(8'h26, 8'h00);
    $display("reset values done");
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    $display("register rows done");
    // Inputs 2 and 3, four samples of 4 cycles, 200-cycle period
    active_state_i = 1'h1;
    wait_on(0, n1);
    check(meas_ch_o, 16'h0001);
    check(meas_result_o, 16'hFFFF);
    check(sample_ch_o, 16'h0002);
    wait_on(0, n1);
    check(meas_ch_o, 16'h0002);
    check(n1, 16'h0010);
    wait_on(2, n1);
    wait_on(3, n1);
    wait_on(2, n1);
    wait_on(3, n2);
    check(16'(n1 + n2), 16'h00C8);
    $display("cycle timing done");
    // Two samples of 8 cycles per input, 800-cycle period
    active_state_i = 1'h0;
    wr(8'h24, 8'h17);
    active_state_i = 1'h1;
    wait_on(0, n1);
    wait_on(0, n1);
    check(n1, 16'h0010);
    check(low_power_o, 16'h0001);
    wait_on(3, n2);
    check(n2, 16'h0300);
    $display("duration codes done");
    // 128 samples per input overrun the period, so the cycle must stretch
    active_state_i = 1'h0;
    wr(8'h24, 8'h70);
    active_state_i = 1'h1;
    wait_on(0, n1);
    wait_on(0, n1);
    check(meas_ch_o, 16'h0002);
    check(n1, 16'h0200);
    check(meas_result_o, 16'hFFFF);
    // Already past the period, so the next cycle follows at once
    wait_on(3, n2);
    check(n2, 16'h0001);
    active_state_i = 1'h0;
    repeat (2) @(negedge core_clk_i);
    check(sampling_o, 16'h0000);
    check(low_power_o, 16'h0000);
    $display("overrun done");
    press_i = 8'h0F;
    repeat (2) @(negedge core_clk_i);
    check(press_detect_o, 16'h000F);
    press_i = 8'h00;
    wr(8'h26, 8'h01);
    wait_on(1, n1);
    check(cal_ch_o, 16'h0000);
    check(input_calibration_value_o, 16'h02A5);
    repeat (3) @(negedge core_clk_i);
    rdc(8'h26, 8'h00);
    // A press mid-attempt must mask detection and keep the trigger set
    wr(8'h26, 8'h80);
    wait_on(4, n1);
    press_i = 8'h80;
    @(negedge core_clk_i);
    check(press_detect_o, 16'h0000);
    @(negedge core_clk_i);
    check(recal_busy_o, 16'h0000);
    repeat (60) @(negedge core_clk_i);
    rdc(8'h26, 8'h80);
    press_i = 8'h00;
    wait_on(1, n1);
    check(cal_ch_o, 16'h0007);
    $display("recalibration done");
    tally_and_finish();
  end
endmodule // touch_sampling_sequencer_bench
